// *** pjh_peer_job.sv ***
// Peer job handshake engine with AXI4-Lite register slave
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// [RL1] Controller presets status word to one
// [RL2] Controller checks start and active clear
// [RL3] Controller sets start bit to request job
// [RL4] Recognised start raises matching active bit
// [RL5] Controller clears start after seeing active
// [RL6] Completion writes status: zero good, else error
// [RL7] Send completion drops send active bit
// [RL8] Start set before recovery is never executed
// [RL9] Controller times out unrecognised start bits
// [RL10] Controller enable holds until job completes
// [RL11] Receive armed first, then waits for sender
// [RL12] Send active rises as transfer begins
// [RL13] Receive active drops after data stored
// [RL14] Start cleared early: job never starts
// [RL15] Receive active holds until data arrives
// [RL16] Run-once service drops enable after status
// [RL17] Controller may re-arm receive after completion
module pjh_peer_job #(
  parameter int unsigned RECOVER_CYC = pjh_pkg::RECOVER_CYC,
  parameter int unsigned RECOG_CYC   = pjh_pkg::RECOG_CYC
) (
  input  wire logic                        REF_CLK,
  input  wire logic                        NRST,
  // Start bits from the controller's output words (pins)
  input  wire logic                        SEND_START,
  input  wire logic                        RECV_START,
  // Active bits to the controller's input words
  output var  logic                        SEND_ACTIVE,
  output var  logic                        RECV_ACTIVE,
  // Status words written at completion
  output var  logic [pjh_pkg::STATUS_W-1:0] SEND_STATUS,
  output var  logic                        SEND_STAT_WE,
  output var  logic [pjh_pkg::STATUS_W-1:0] RECV_STATUS,
  output var  logic                        RECV_STAT_WE,
  // Transfer engine
  output var  logic                        SEND_GO,
  output var  logic                        RECV_GO,
  input  wire pjh_pkg::pjh_result_t        SEND_RESULT,
  input  wire pjh_pkg::pjh_result_t        RECV_RESULT,
  // AXI4-Lite slave
  input  wire logic [pjh_pkg::ADDR_W-1:0]  S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output var  logic                        S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output var  logic                        S_AXI_WREADY,
  output var  logic [1:0]                  S_AXI_BRESP,
  output var  logic                        S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [pjh_pkg::ADDR_W-1:0]  S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output var  logic                        S_AXI_ARREADY,
  output var  logic [31:0]                 S_AXI_RDATA,
  output var  logic [1:0]                  S_AXI_RRESP,
  output var  logic                        S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  output var  logic                        IRQ
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (RECOG_CYC < 1 || RECOG_CYC > 255)
    $error("RECOG_CYC must lie in 1..255");
  if (RECOVER_CYC < 1 || RECOVER_CYC > 65535)
    $error("RECOVER_CYC must lie in 1..65535");

  localparam logic [7:0]  RECOG_LAST  = 8'(RECOG_CYC - 1);
  localparam logic [15:0] RECOVER_END = 16'(RECOVER_CYC);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                          send_s1;   // Synchroniser first stages
    logic                          send_s2;
    logic                          recv_s1;
    logic                          recv_s2;
    logic [15:0]                   rec_cnt;   // Recovery counter
    pjh_pkg::pjh_job_t             send;
    pjh_pkg::pjh_job_t             recv;
    logic [1:0]                    ctrl;
    logic [pjh_pkg::EV_W-1:0]      sts;
    logic [pjh_pkg::EV_W-1:0]      mask;
    logic                          irq;
    logic                          aw_have;   // Write address held
    logic [pjh_pkg::ADDR_W-1:0]    aw_addr;
    logic                          w_have;    // Write data held
    logic [31:0]                   w_data;
    logic [3:0]                    w_strb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
  } pjh_state_t;

  pjh_state_t st_reg;   // Registered state
  pjh_state_t st_next;  // Next state

  // ****************************************************************
  // Job step, shared by send and receive
  // ****************************************************************
  // One sequence serves both directions; only the engine behind GO differs
  function automatic pjh_pkg::pjh_step_t job_step(
    input pjh_pkg::pjh_job_t    j,
    input logic                 start,
    input logic                 en,
    input logic                 ready,
    input pjh_pkg::pjh_result_t res
  );
    pjh_pkg::pjh_step_t s;
    s          = '0;
    s.job      = j;
    s.job.go      = 1'b0;
    s.job.stat_we = 1'b0;
    case (j.state)
      pjh_pkg::JOB_IDLE:
      begin
        if (!start)
        begin
          s.job.stale = 1'b0;   // A fresh edge is needed after a stale start
        end
        else if (!ready)
        begin
          s.job.stale = 1'b1;   // [RL8]
          s.ev_stale  = !j.stale;
        end
        else if (en && !j.stale)
        begin
          s.job.state = pjh_pkg::JOB_RECOG;
          s.job.cnt   = 8'h00;
        end
      end
      pjh_pkg::JOB_RECOG:
      begin
        if (!start)
        begin
          // Start dropped before recognition: job is dropped and its abort event is set
          s.job.state = pjh_pkg::JOB_IDLE;   // [RL14]
          s.ev_abort  = 1'b1;
        end
        else if (j.cnt == RECOG_LAST)
        begin
          s.job.state  = pjh_pkg::JOB_ACTIVE;
          s.job.active = 1'b1;   // [RL4]
          s.job.go     = 1'b1;   // [RL11] [RL12]
        end
        else
        begin
          s.job.cnt = j.cnt + 8'h01;
        end
      end
      pjh_pkg::JOB_ACTIVE:
      begin
        // No timeout: the job waits for the engine however long it takes
        if (res.done)   // [RL15]
        begin
          s.job.state   = pjh_pkg::JOB_DONE;
          s.job.active  = 1'b0;        // [RL7] [RL13]
          s.job.status  = res.code;    // [RL6]
          s.job.stat_we = 1'b1;        // [RL6]
          s.ev_done     = 1'b1;
        end
      end
      pjh_pkg::JOB_DONE:
      begin
        // A start still held now belongs to the finished job
        if (!start)
        begin
          s.job.state = pjh_pkg::JOB_IDLE;
        end
      end
      default:
      begin
        s.job.state = pjh_pkg::JOB_IDLE;
      end
    endcase
    return s;
  endfunction : job_step

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    pjh_pkg::pjh_step_t        ss;
    pjh_pkg::pjh_step_t        rs;
    logic                      ready;
    logic                      restart;
    logic [pjh_pkg::EV_W-1:0]  ev;
    logic [pjh_pkg::EV_W-1:0]  clr;
    ss      = '0;
    rs      = '0;
    ev      = '0;
    clr     = '0;
    restart = 1'b0;
    st_next = st_reg;
    // Start pins pass two flip-flops before any logic looks at them
    st_next.send_s1 = SEND_START;
    st_next.send_s2 = st_reg.send_s1;
    st_next.recv_s1 = RECV_START;
    st_next.recv_s2 = st_reg.recv_s1;
    ready = (st_reg.rec_cnt == RECOVER_END);

    // Write path: address and data may arrive in either order
    if (S_AXI_AWVALID && st_reg.awready)
    begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st_reg.wready)
    begin
      st_next.w_have = 1'b1;
      st_next.w_data = S_AXI_WDATA;
      st_next.w_strb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY)
    begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid)
    begin
      st_next.aw_have = 1'b0;
      st_next.w_have  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = pjh_pkg::RESP_OKAY;
      if (st_reg.aw_addr == pjh_pkg::CTRL_OFS)
      begin
        if (st_reg.w_strb[0])
        begin
          st_next.ctrl = st_reg.w_data[1:0];
          restart      = st_reg.w_data[pjh_pkg::CTRL_RESTART];
        end
      end
      else if (st_reg.aw_addr == pjh_pkg::IRQ_STAT_OFS)
      begin
        if (st_reg.w_strb[0])
        begin
          clr = st_reg.w_data[pjh_pkg::EV_W-1:0];
        end
      end
      else if (st_reg.aw_addr == pjh_pkg::IRQ_MASK_OFS)
      begin
        if (st_reg.w_strb[0])
        begin
          st_next.mask = st_reg.w_data[pjh_pkg::EV_W-1:0];
        end
      end
      else if (st_reg.aw_addr == pjh_pkg::JOB_STATE_OFS ||
               st_reg.aw_addr == pjh_pkg::SEND_STAT_OFS ||
               st_reg.aw_addr == pjh_pkg::RECV_STAT_OFS)
      begin
        st_next.bresp = pjh_pkg::RESP_OKAY;   // Read-only: write ignored
      end
      else
      begin
        st_next.bresp = pjh_pkg::RESP_SLVERR;  // Unmapped
      end
    end
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready  = !st_next.w_have && !st_next.bvalid;

    // Read path: one cycle from address to data
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      st_next.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = pjh_pkg::RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (S_AXI_ARADDR == pjh_pkg::CTRL_OFS)
      begin
        st_next.rdata[1:0] = st_reg.ctrl;
      end
      else if (S_AXI_ARADDR == pjh_pkg::IRQ_STAT_OFS)
      begin
        st_next.rdata[pjh_pkg::EV_W-1:0] = st_reg.sts;
      end
      else if (S_AXI_ARADDR == pjh_pkg::IRQ_MASK_OFS)
      begin
        st_next.rdata[pjh_pkg::EV_W-1:0] = st_reg.mask;
      end
      else if (S_AXI_ARADDR == pjh_pkg::JOB_STATE_OFS)
      begin
        st_next.rdata[pjh_pkg::JS_SEND_LSB +: 2] = st_reg.send.state;
        st_next.rdata[pjh_pkg::JS_RECV_LSB +: 2] = st_reg.recv.state;
        st_next.rdata[pjh_pkg::JS_READY]         = ready;
        st_next.rdata[pjh_pkg::JS_SEND_STALE]    = st_reg.send.stale;
        st_next.rdata[pjh_pkg::JS_RECV_STALE]    = st_reg.recv.stale;
      end
      else if (S_AXI_ARADDR == pjh_pkg::SEND_STAT_OFS)
      begin
        st_next.rdata[pjh_pkg::STATUS_W-1:0] = st_reg.send.status;
      end
      else if (S_AXI_ARADDR == pjh_pkg::RECV_STAT_OFS)
      begin
        st_next.rdata[pjh_pkg::STATUS_W-1:0] = st_reg.recv.status;
      end
      else
      begin
        st_next.rresp = pjh_pkg::RESP_SLVERR;  // Unmapped reads zero
      end
    end
    st_next.arready = !st_next.rvalid;

    // Recovery: after a restart, a start that an idle job sees before recovery ends counts as stale
    if (restart)
    begin
      st_next.rec_cnt = 16'h0000;   // [RL8]
    end
    else if (!ready)
    begin
      st_next.rec_cnt = st_reg.rec_cnt + 16'h0001;
    end

    // Jobs
    ss = job_step(st_reg.send, st_reg.send_s2, st_reg.ctrl[pjh_pkg::CTRL_SEND_EN],
                  ready, SEND_RESULT);
    rs = job_step(st_reg.recv, st_reg.recv_s2, st_reg.ctrl[pjh_pkg::CTRL_RECV_EN],
                  ready, RECV_RESULT);
    st_next.send = ss.job;
    st_next.recv = rs.job;

    // Sticky events: a set in the clearing cycle wins
    ev[pjh_pkg::EV_SEND_DONE]  = ss.ev_done;
    ev[pjh_pkg::EV_RECV_DONE]  = rs.ev_done;
    ev[pjh_pkg::EV_SEND_STALE] = ss.ev_stale;
    ev[pjh_pkg::EV_RECV_STALE] = rs.ev_stale;
    ev[pjh_pkg::EV_SEND_ABORT] = ss.ev_abort;
    ev[pjh_pkg::EV_RECV_ABORT] = rs.ev_abort;
    st_next.sts = (st_reg.sts & ~clr) | ev;
    st_next.irq = |(st_next.sts & st_next.mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_reg             <= '0;
      st_reg.ctrl        <= pjh_pkg::CTRL_RST;
      st_reg.send.status <= pjh_pkg::STATUS_RST;
      st_reg.recv.status <= pjh_pkg::STATUS_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flip-flops
  // ****************************************************************
  assign SEND_ACTIVE   = st_reg.send.active;
  assign RECV_ACTIVE   = st_reg.recv.active;
  assign SEND_STATUS   = st_reg.send.status;
  assign SEND_STAT_WE  = st_reg.send.stat_we;
  assign RECV_STATUS   = st_reg.recv.status;
  assign RECV_STAT_WE  = st_reg.recv.stat_we;
  assign SEND_GO       = st_reg.send.go;
  assign RECV_GO       = st_reg.recv.go;
  assign S_AXI_AWREADY = st_reg.awready;
  assign S_AXI_WREADY  = st_reg.wready;
  assign S_AXI_BVALID  = st_reg.bvalid;
  assign S_AXI_BRESP   = st_reg.bresp;
  assign S_AXI_ARREADY = st_reg.arready;
  assign S_AXI_RVALID  = st_reg.rvalid;
  assign S_AXI_RDATA   = st_reg.rdata;
  assign S_AXI_RRESP   = st_reg.rresp;
  assign IRQ           = st_reg.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);

  recog_raises_active_a: assert property ( // RL4
    st_reg.send.state == pjh_pkg::JOB_RECOG && st_reg.send_s2 &&
    st_reg.send.cnt == RECOG_LAST |=> SEND_ACTIVE && SEND_GO)
    else $error("Recognised send start did not raise active");

  status_on_done_a: assert property ( // RL6
    RECV_ACTIVE && RECV_RESULT.done |=>
    RECV_STAT_WE && RECV_STATUS == $past(RECV_RESULT.code))
    else $error("Receive status not written at completion");

  send_done_drop_a: assert property ( // RL7
    SEND_ACTIVE && SEND_RESULT.done |=> !SEND_ACTIVE ##1 !SEND_ACTIVE)
    else $error("Send active did not drop at completion");

  stale_never_runs_a: assert property ( // RL8
    st_reg.send.stale && st_reg.send_s2 |=> !SEND_ACTIVE && !SEND_GO)
    else $error("Stale send start was executed");

  recv_arm_go_a: assert property ( // RL11
    $rose(RECV_ACTIVE) |-> RECV_GO)
    else $error("Receive active without arming receiver");

  send_go_active_a: assert property ( // RL12
    SEND_GO |-> $rose(SEND_ACTIVE))
    else $error("Send transfer began without active rising");

  recv_drop_stored_a: assert property ( // RL13
    $fell(RECV_ACTIVE) |-> $past(RECV_RESULT.done) && RECV_STAT_WE)
    else $error("Receive active dropped before data stored");

  early_clear_a: assert property ( // RL14
    st_reg.send.state == pjh_pkg::JOB_RECOG && !st_reg.send_s2 |=>
    st_reg.send.state == pjh_pkg::JOB_IDLE && !SEND_ACTIVE && !SEND_GO)
    else $error("Send job started after early start clear");

  recv_hold_a: assert property ( // RL15
    RECV_ACTIVE && !RECV_RESULT.done |=> RECV_ACTIVE)
    else $error("Receive active dropped without data");

endmodule : pjh_peer_job

`default_nettype wire

// *** pjh_pkg.sv ***
// Package of constants and types for the peer job handshake block
package pjh_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 10;   // REF_CLK period
  localparam int unsigned RECOVER_TIME_NS = 2000; // Recovery after reset
  localparam int unsigned RECOG_TIME_NS   = 50;   // Start must stand this long
  // Least times round up to whole cycles
  localparam int unsigned RECOVER_CYC = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOG_CYC   = (RECOG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam int unsigned ADDR_W        = 8;
  localparam logic [7:0]  CTRL_OFS      = 8'h00; // Enables and recovery restart
  localparam logic [7:0]  IRQ_STAT_OFS  = 8'h04; // Sticky events, write one to clear
  localparam logic [7:0]  IRQ_MASK_OFS  = 8'h08; // Event mask, same layout
  localparam logic [7:0]  JOB_STATE_OFS = 8'h0C; // Live job state
  localparam logic [7:0]  SEND_STAT_OFS = 8'h10; // Last send status word
  localparam logic [7:0]  RECV_STAT_OFS = 8'h14; // Last receive status word

  // Control bits
  localparam int unsigned CTRL_SEND_EN = 0;
  localparam int unsigned CTRL_RECV_EN = 1;
  localparam int unsigned CTRL_RESTART = 2; // Self clearing
  localparam logic [1:0]  CTRL_RST     = 2'h3;

  // Event bits
  localparam int unsigned EV_W         = 6;
  localparam int unsigned EV_SEND_DONE = 0;
  localparam int unsigned EV_RECV_DONE = 1;
  localparam int unsigned EV_SEND_STALE = 2;
  localparam int unsigned EV_RECV_STALE = 3;
  localparam int unsigned EV_SEND_ABORT = 4;
  localparam int unsigned EV_RECV_ABORT = 5;

  // Job state register fields
  localparam int unsigned JS_SEND_LSB = 0;
  localparam int unsigned JS_RECV_LSB = 2;
  localparam int unsigned JS_READY    = 4;
  localparam int unsigned JS_SEND_STALE = 5;
  localparam int unsigned JS_RECV_STALE = 6;

  localparam int unsigned STATUS_W   = 16;
  localparam logic [15:0] STATUS_RST = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  // Gray coded along idle, recognise, active, done
  typedef enum logic [1:0] {
    JOB_IDLE   = 2'b00,
    JOB_RECOG  = 2'b01,
    JOB_ACTIVE = 2'b11,
    JOB_DONE   = 2'b10
  } pjh_job_state_t;

  // Completion report from the transfer engine
  typedef struct packed {
    logic                done;
    logic [STATUS_W-1:0] code;
  } pjh_result_t;

  // One job's state
  typedef struct packed {
    pjh_job_state_t      state;
    logic [7:0]          cnt;
    logic                stale;
    logic                active;
    logic                go;
    logic                stat_we;
    logic [STATUS_W-1:0] status;
  } pjh_job_t;

  // Job step result with its events
  typedef struct packed {
    pjh_job_t job;
    logic     ev_done;
    logic     ev_stale;
    logic     ev_abort;
  } pjh_step_t;

endpackage : pjh_pkg

// *** pjh_ctrl_model.sv ***
// Controller model driving one job's start bit
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Controller model: presets status, raises start, waits for active
// ****************************************************************
module pjh_ctrl_model #(
  parameter int unsigned WD_CYC = 40 // Watchdog length in cycles
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req,         // Bench asks for one job
  input  wire logic        early,       // Fault mode: drop start too soon
  input  wire logic        active,      // Job active bit from the module
  input  wire logic        stat_we,     // Status write strobe
  input  wire logic [15:0] status,      // Status written at completion
  output var  logic        start,       // Job start bit
  output var  logic [15:0] status_word  // Controller copy of the status
);
  int unsigned wd; // Cycles since start was raised

  // Start bit sequencing, changed only just after a clock edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      start       <= 1'b0;
      wd          <= 0;
      status_word <= 16'h0000;
    end
    else
    begin
      if (stat_we)
        status_word <= status;
      // Request held by the bench stands for the enabling condition
      if (req && !start && !active)
      begin
        status_word <= 16'h0001;
        start       <= 1'b1;
        wd          <= 0;
      end
      else if (start)
      begin
        wd <= wd + 1;
        if (active)
          start <= 1'b0;
        else if (early && wd == 1)
          start <= 1'b0; // Deliberate fault, only when the bench asks
        else if (wd == WD_CYC)
          start <= 1'b0;
      end
    end
  end
endmodule : pjh_ctrl_model
`default_nettype wire

// *** pjh_peer_job_tb.sv ***
// Self-checking testbench for the peer job handshake block
`timescale 1ns/10ps
`default_nettype none
module pjh_peer_job_tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } pjh_row_t;
  logic                 ref_clk, nrst, snd_start, rcv_start, snd_act, rcv_act;
  logic                 snd_we, rcv_we, snd_go, rcv_go, irq, snd_req, rcv_req;
  logic                 snd_early, snd_act_q;
  logic [15:0]          snd_stat, rcv_stat, snd_word, rcv_word;
  pjh_pkg::pjh_result_t snd_res, rcv_res;
  logic [7:0]           awaddr, araddr;
  logic                 awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready;
  logic [31:0]          wdata, rdata, rd;
  logic [1:0]           bresp, rresp, rs;
  int                   num_errors, check_count, snd_rises;
  // Reads after recovery: address, data, response
  pjh_row_t rows [8] = '{'{8'h00, 32'h3, 2'h0}, '{8'h04, 32'h0, 2'h0},
    '{8'h08, 32'h0, 2'h0}, '{8'h0C, 32'h10, 2'h0}, '{8'h10, 32'h0, 2'h0},
    '{8'h14, 32'h0, 2'h0}, '{8'h18, 32'h0, 2'h2}, '{8'h1C, 32'h0, 2'h2}};

  // ****************************************************************
  // Design, controller models, clock
  // ****************************************************************
  pjh_peer_job #(.RECOVER_CYC(10), .RECOG_CYC(5)) i_pjh_peer_job (
    .REF_CLK(ref_clk), .NRST(nrst), .SEND_START(snd_start), .RECV_START(rcv_start),
    .SEND_ACTIVE(snd_act), .RECV_ACTIVE(rcv_act), .SEND_STATUS(snd_stat),
    .SEND_STAT_WE(snd_we), .RECV_STATUS(rcv_stat), .RECV_STAT_WE(rcv_we),
    .SEND_GO(snd_go), .RECV_GO(rcv_go), .SEND_RESULT(snd_res), .RECV_RESULT(rcv_res),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq));
  pjh_ctrl_model i_pjh_ctrl_model_snd (.clk(ref_clk), .nrst(nrst), .req(snd_req),
    .early(snd_early), .active(snd_act), .stat_we(snd_we), .status(snd_stat),
    .start(snd_start), .status_word(snd_word));
  pjh_ctrl_model i_pjh_ctrl_model_rcv (.clk(ref_clk), .nrst(nrst), .req(rcv_req),
    .early(1'b0), .active(rcv_act), .stat_we(rcv_we), .status(rcv_stat),
    .start(rcv_start), .status_word(rcv_word));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Counts send active rises
  always @(posedge ref_clk)
  begin
    if (snd_act === 1'b1 && snd_act_q !== 1'b1)
      snd_rises++;
    snd_act_q <= snd_act;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    if (num_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // A wait that used up its bound
  task automatic tmo;
    chk(32'h0, 32'h1);
    finish_test();
  endtask : tmo
  // AW and W offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        chk(bresp, 32'h0);
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 100; n++)
    begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : axi_rd
  // Bounded wait for active: 0 send, 1 receive
  task automatic wait_hi(input int k);
    for (int n = 0; n < 200; n++)
    begin
      @(negedge ref_clk);
      if ((k == 0 && snd_act === 1'b1) || (k == 1 && rcv_act === 1'b1))
        return;
    end
    tmo();
  endtask : wait_hi
  // One-cycle request to a controller model
  task automatic job_req(input int k);
    @(posedge ref_clk);
    snd_req <= (k == 0);
    rcv_req <= (k == 1);
    @(posedge ref_clk);
    snd_req <= 1'b0;
    rcv_req <= 1'b0;
  endtask : job_req
  // Engine completion pulse; returns just after the edge that takes it
  task automatic done_pulse(input int k, input logic [15:0] code);
    @(posedge ref_clk);
    if (k == 0)
      snd_res <= '{done: 1'b1, code: code};
    else
      rcv_res <= '{done: 1'b1, code: code};
    @(posedge ref_clk);
    snd_res.done <= 1'b0;
    rcv_res.done <= 1'b0;
    @(negedge ref_clk);
  endtask : done_pulse

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    {nrst, snd_req, rcv_req, snd_early, awvalid, wvalid, bready} = 7'h00;
    {arvalid, rready, snd_act_q} = 3'h0;
    {awaddr, araddr, wdata} = 48'h0;
    snd_res = '0;
    rcv_res = '0;
    num_errors = 0;
    check_count = 0;
    snd_rises = 0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    // Start raised while the module still recovers
    job_req(0);
    repeat (60) @(posedge ref_clk);
    chk(snd_rises, 0);
    chk(snd_start, 1'b0);
    axi_rd(8'h04, rd, rs);
    chk(rd, 32'h4);
    axi_wr(8'h04, 32'h3F);
    axi_wr(8'h10, 32'hFFFFFFFF);
    foreach (rows[i])
    begin
      axi_rd(rows[i].addr, rd, rs);
      chk(rd, rows[i].data);
      chk(rs, rows[i].resp);
    end
    // Receive armed first, then the send job
    axi_wr(8'h08, 32'h3);
    job_req(1);
    wait_hi(1);
    chk(rcv_go, 1'b1);
    job_req(0);
    wait_hi(0);
    chk(snd_go, 1'b1);
    chk(rcv_act, 1'b1);
    done_pulse(0, 16'h0000);
    chk(snd_act, 1'b0);
    chk({snd_we, snd_stat}, 17'h10000);
    repeat (30) @(negedge ref_clk);
    chk(rcv_act, 1'b1);
    chk(snd_word, 16'h0000);
    chk(irq, 1'b1);
    done_pulse(1, 16'h0005);
    chk(rcv_act, 1'b0);
    chk({rcv_we, rcv_stat}, 17'h10005);
    axi_rd(8'h04, rd, rs);
    chk(rd, 32'h3);
    chk(rcv_word, 32'h5);
    axi_wr(8'h04, 32'h1);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'b1);
    axi_wr(8'h04, 32'h2);
    repeat (2) @(negedge ref_clk);
    chk(irq, 1'b0);
    // Receive service armed again
    job_req(1);
    wait_hi(1);
    chk(rcv_act, 1'b1);
    // Start dropped before the module answered
    @(posedge ref_clk);
    snd_early <= 1'b1;
    job_req(0);
    repeat (40) @(negedge ref_clk);
    chk(snd_rises, 1);
    axi_rd(8'h04, rd, rs);
    chk(rd, 32'h10);
    chk(irq, 1'b0);
    finish_test();
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    tmo();
  end
endmodule : pjh_peer_job_tb
`default_nettype wire
